/* File: src/serial_packet_assembler.sv */
// Notes on behaviour
// - After reset the port runs eight data bits, no parity, one stop.
// - Format codes 1 to 10 select 8N1 through 7O2 in table order.
// - Rate codes 8 to 14 select 7200 down to 300 bits per second.
// - Command mode forces default serial settings; data mode restores them.
// - Minimum packet size 1 to 255, default 1, gates the timeout close.
// - Maximum packet size 1 to 256, default 256, closes a packet when hit.
// - Character timeout counts quarter character times, default 10.
// - Gap timer runs once minimum is collected; long gap sends the data.
// - Retransmission limit, default 5, caps resends after the first send.
// - Buffer closes at max size or at minimum plus timeout, first wins.
// - Escape byte defaults to 43; zero turns escape detection off.
`timescale 1ns/1ps
module serial_packet_assembler #(
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [assembler_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Serial data from the attached device
    input  wire logic                          serial_rxd,
    // Packet stream toward the radio
    output logic      [7:0]                    pkt_data,
    output logic                               pkt_valid,
    output logic                               pkt_last,
    input  wire logic                          pkt_ready,
    // Side information for the radio
    output logic      [7:0]                    retx_limit,
    output logic                               escape_detected
);
    import assembler_pkg::*;

    typedef struct packed {
        logic [7:0]  bit_rate;
        logic [7:0]  format;
        logic [7:0]  min_bytes;
        logic [15:0] max_bytes;
        logic [7:0]  retx;
        logic [7:0]  gap_q;
        logic [7:0]  escape;
        logic        cmd_mode;
        logic [3:0]  status;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [15:0] div_cnt;
        rx_state_t   rx_state;
        logic [3:0]  tick_cnt;
        logic [2:0]  bit_cnt;
        logic [7:0]  shift;
        logic        par_acc;
        logic        stop_left;
        logic [7:0]  qdiv;
        logic [7:0]  gap_cnt;
        logic [8:0]  fill;
        logic        hold_valid;
        logic [7:0]  hold_byte;
        logic        close_pend;
        logic        push_valid;
        logic [8:0]  push_data;
        logic        esc_pulse;
    } state_t;

    localparam state_t RESET_STATE = '{
        bit_rate:  DEFAULT_BAUD_CODE,
        format:    DEFAULT_FORMAT_CODE,
        min_bytes: DEFAULT_MIN_BYTES,
        max_bytes: DEFAULT_MAX_BYTES,
        retx:      DEFAULT_RETX,
        gap_q:     DEFAULT_GAP_Q,
        escape:    DEFAULT_ESCAPE,
        rx_state:  RX_IDLE,
        default:   '0
    };

    state_t       r;
    state_t       n;
    char_format_t fmt;
    logic [15:0]  divisor;
    logic [5:0]   char_bits;
    logic [7:0]   quarter_len;
    logic         tick;
    logic         quarter_tick;
    logic         byte_done;
    logic [7:0]   rx_byte;
    logic [3:0]   st_set;
    logic [3:0]   st_clr;
    logic [8:0]   max_lim;
    logic [8:0]   min_lim;
    logic         push_free;
    logic         setup;
    logic         wr;
    logic         mapped;
    logic [31:0]  rd_val;

    fifo_if #(.WIDTH(9)) pkt_q ();

    packet_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .pclk    (pclk),
        .presetn (presetn),
        .port    (pkt_q.store)
    );

    always_comb begin
        n            = r;
        n.pready     = 1'b0;
        n.pslverr    = 1'b0;
        n.esc_pulse  = 1'b0;
        tick         = 1'b0;
        quarter_tick = 1'b0;
        byte_done    = 1'b0;
        st_set       = '0;
        st_clr       = '0;
        rd_val       = '0;
        mapped       = 1'b1;

        // Command mode runs the port on defaults, configured values return
        // on leaving it
        divisor = baud_divisor(r.cmd_mode ? DEFAULT_BAUD_CODE
                                          : r.bit_rate);
        fmt = decode_format(r.cmd_mode ? DEFAULT_FORMAT_CODE
                                       : r.format);
        char_bits = 6'd1 + (fmt.eight ? 6'd8 : 6'd7)
                  + {5'b0, fmt.parity_en} + (fmt.two_stop ? 6'd2 : 6'd1);
        quarter_len = 8'(char_bits * QUARTER_TICKS);
        rx_byte = fmt.eight ? r.shift : {1'b0, r.shift[7:1]};
        // Out-of-range sizes are clamped so a packet can never run away
        max_lim = (r.max_bytes == '0 || r.max_bytes > 16'h0100)
                ? 9'h100 : r.max_bytes[8:0];
        min_lim = (r.min_bytes == '0) ? 9'h001 : {1'b0, r.min_bytes};

        // APB: answer one cycle after setup, so no access has a wait state
        setup = psel && !penable;
        wr    = psel && penable && pwrite && r.pready;
        unique case (paddr)
            ADDR_BIT_RATE: rd_val = {24'h0, r.bit_rate};
            ADDR_FORMAT:   rd_val = {24'h0, r.format};
            ADDR_MIN:      rd_val = {24'h0, r.min_bytes};
            ADDR_MAX:      rd_val = {16'h0, r.max_bytes};
            ADDR_RETX:     rd_val = {24'h0, r.retx};
            ADDR_GAP:      rd_val = {24'h0, r.gap_q};
            ADDR_ESCAPE:   rd_val = {24'h0, r.escape};
            ADDR_CONTROL:  rd_val = {31'h0, r.cmd_mode};
            ADDR_STATUS:   rd_val = {28'h0, r.status};
            ADDR_FILL:     rd_val = {23'h0, r.fill};
            default:       mapped = 1'b0;
        endcase
        if (setup) begin
            n.prdata  = rd_val;
            n.pready  = 1'b1;
            n.pslverr = !mapped;
        end
        if (wr) begin
            unique case (paddr)
                ADDR_BIT_RATE: n.bit_rate  = pwdata[7:0];
                ADDR_FORMAT:   n.format    = pwdata[7:0];
                ADDR_MIN:      n.min_bytes = pwdata[7:0];
                ADDR_MAX:      n.max_bytes = pwdata[15:0];
                ADDR_RETX:     n.retx      = pwdata[7:0];
                ADDR_GAP:      n.gap_q     = pwdata[7:0];
                ADDR_ESCAPE:   n.escape    = pwdata[7:0];
                ADDR_CONTROL:  n.cmd_mode  = pwdata[0];
                ADDR_STATUS:   st_clr      = pwdata[3:0];
                default:       n.cmd_mode  = r.cmd_mode;
            endcase
        end

        // Oversample divider; >= copes with a rate change mid-count
        if (r.div_cnt >= divisor - 16'h0001) begin
            n.div_cnt = '0;
            tick      = 1'b1;
        end else begin
            n.div_cnt = r.div_cnt + 16'h0001;
        end

        // Receiver, sampling each bit at its middle
        if (tick) begin
            n.tick_cnt = r.tick_cnt + 4'h1;
            unique case (r.rx_state)
                RX_IDLE: begin
                    n.tick_cnt = '0;
                    if (!serial_rxd) begin
                        n.rx_state = RX_START;
                    end
                end
                RX_START: begin
                    if (r.tick_cnt == 4'h7) begin
                        n.tick_cnt = '0;
                        n.bit_cnt  = '0;
                        n.par_acc  = fmt.parity_odd;
                        n.rx_state = serial_rxd ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (r.tick_cnt == 4'hf) begin
                        n.shift   = {serial_rxd, r.shift[7:1]};
                        n.par_acc = r.par_acc ^ serial_rxd;
                        n.bit_cnt = r.bit_cnt + 3'h1;
                        if (r.bit_cnt == (fmt.eight ? 3'h7 : 3'h6)) begin
                            n.stop_left = fmt.two_stop;
                            n.rx_state  = fmt.parity_en ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (r.tick_cnt == 4'hf) begin
                        st_set[ST_PARITY] = r.par_acc ^ serial_rxd;
                        n.rx_state = RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (r.tick_cnt == 4'hf) begin
                        st_set[ST_FRAMING] = !serial_rxd;
                        if (r.stop_left && serial_rxd) begin
                            n.stop_left = 1'b0;
                        end else begin
                            byte_done  = serial_rxd;
                            n.rx_state = RX_IDLE;
                        end
                    end
                end
            endcase
        end

        // Quarter character clock for the gap timer
        if (tick) begin
            if (r.qdiv >= quarter_len - 8'h01) begin
                n.qdiv       = '0;
                quarter_tick = 1'b1;
            end else begin
                n.qdiv = r.qdiv + 8'h01;
            end
        end

        // Escape byte watch, zero switches it off
        if (byte_done && r.escape != 8'h00 && rx_byte == r.escape) begin
            st_set[ST_ESCAPE] = 1'b1;
            n.esc_pulse = 1'b1;
        end

        // A drained push frees the slot this very cycle
        push_free = !r.push_valid || pkt_q.push_ready;
        if (r.push_valid && pkt_q.push_ready) begin
            n.push_valid = 1'b0;
        end

        // Newest byte stays in hold so a later timeout can still mark it last
        if (byte_done && !r.cmd_mode) begin
            if (r.hold_valid && !push_free) begin
                st_set[ST_OVERRUN] = 1'b1;
            end else begin
                if (r.hold_valid) begin
                    n.push_valid = 1'b1;
                    n.push_data  = {r.close_pend, r.hold_byte};
                end
                n.hold_valid = 1'b1;
                n.hold_byte  = rx_byte;
                n.fill       = (r.close_pend || !r.hold_valid)
                             ? 9'h001 : r.fill + 9'h001;
                n.close_pend = (n.fill >= max_lim);
                n.gap_cnt    = '0;
            end
        end else if (r.hold_valid && push_free &&
                     (r.close_pend || (r.fill >= min_lim &&
                                       r.gap_cnt > r.gap_q))) begin
            n.push_valid = 1'b1;
            n.push_data  = {1'b1, r.hold_byte};
            n.hold_valid = 1'b0;
            n.close_pend = 1'b0;
            n.fill       = '0;
            n.gap_cnt    = '0;
        end else if (r.hold_valid && r.fill >= min_lim && quarter_tick &&
                     r.gap_cnt != 8'hff) begin
            n.gap_cnt = r.gap_cnt + 8'h01;
        end

        // Sticky status: a new event beats a clear in the same cycle
        n.status = (r.status & ~st_clr) | st_set;
    end

    // Reset loads every default and empties the partial buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= RESET_STATE;
        end else begin
            r <= n;
        end
    end

    // Queue toward the radio; its full flag stalls the hold register
    assign pkt_q.push_valid = r.push_valid;
    assign pkt_q.push_data  = r.push_data;
    assign pkt_q.pop_ready  = pkt_ready;

    // All outputs come from state registers or the queue's output register
    assign prdata          = r.prdata;
    assign pready          = r.pready;
    assign pslverr         = r.pslverr;
    assign pkt_data        = pkt_q.pop_data[7:0];
    assign pkt_last        = pkt_q.pop_data[8];
    assign pkt_valid       = pkt_q.pop_valid;
    assign retx_limit      = r.retx;
    assign escape_detected = r.esc_pulse;
endmodule

/* File: src/assembler_pkg.sv */
package assembler_pkg;

    // Clock and serial timing
    localparam int CLK_HZ        = 50_000_000;
    localparam int OVERSAMPLE    = 16;
    localparam int QUARTER_TICKS = OVERSAMPLE / 4;
    localparam int ADDR_W        = 8;

    // Register byte offsets
    localparam logic [7:0] ADDR_BIT_RATE = 8'h00;
    localparam logic [7:0] ADDR_FORMAT   = 8'h04;
    localparam logic [7:0] ADDR_MIN      = 8'h08;
    localparam logic [7:0] ADDR_MAX      = 8'h0c;
    localparam logic [7:0] ADDR_RETX     = 8'h10;
    localparam logic [7:0] ADDR_GAP      = 8'h14;
    localparam logic [7:0] ADDR_ESCAPE   = 8'h18;
    localparam logic [7:0] ADDR_CONTROL  = 8'h1c;
    localparam logic [7:0] ADDR_STATUS   = 8'h20;
    localparam logic [7:0] ADDR_FILL     = 8'h24;

    // Reset values
    localparam logic [7:0]  DEFAULT_BAUD_CODE   = 8'h0b;
    localparam logic [7:0]  DEFAULT_FORMAT_CODE = 8'h01;
    localparam logic [7:0]  DEFAULT_MIN_BYTES   = 8'h01;
    localparam logic [15:0] DEFAULT_MAX_BYTES   = 16'h0100;
    localparam logic [7:0]  DEFAULT_RETX        = 8'h05;
    localparam logic [7:0]  DEFAULT_GAP_Q       = 8'h0a;
    localparam logic [7:0]  DEFAULT_ESCAPE      = 8'h2b;

    // Status bit positions
    localparam int ST_PARITY  = 0;
    localparam int ST_FRAMING = 1;
    localparam int ST_OVERRUN = 2;
    localparam int ST_ESCAPE  = 3;

    // Serial rates in bits per second
    localparam int RATE_7200 = 7200;
    localparam int RATE_4800 = 4800;
    localparam int RATE_3600 = 3600;
    localparam int RATE_2400 = 2400;
    localparam int RATE_1200 = 1200;
    localparam int RATE_600  = 600;
    localparam int RATE_300  = 300;

    typedef enum logic [2:0] {
        RX_IDLE   = 3'b000,
        RX_START  = 3'b001,
        RX_DATA   = 3'b011,
        RX_PARITY = 3'b010,
        RX_STOP   = 3'b110
    } rx_state_t;

    typedef struct packed {
        logic eight;
        logic parity_en;
        logic parity_odd;
        logic two_stop;
    } char_format_t;

    // Oversample divisor per rate code; unknown codes fall to the default
    function automatic logic [15:0] baud_divisor(input logic [7:0] code);
        int rate;
        unique case (code)
            8'h08:   rate = RATE_7200;
            8'h09:   rate = RATE_4800;
            8'h0a:   rate = RATE_3600;
            8'h0b:   rate = RATE_2400;
            8'h0c:   rate = RATE_1200;
            8'h0d:   rate = RATE_600;
            8'h0e:   rate = RATE_300;
            default: rate = RATE_2400;
        endcase
        return 16'(CLK_HZ / (OVERSAMPLE * rate));
    endfunction

    // Character format per code; unknown codes fall to 8N1
    function automatic char_format_t decode_format(input logic [7:0] code);
        unique case (code)
            8'h02:   return '{1'b1, 1'b0, 1'b0, 1'b1};
            8'h03:   return '{1'b1, 1'b1, 1'b0, 1'b0};
            8'h04:   return '{1'b1, 1'b1, 1'b1, 1'b0};
            8'h05:   return '{1'b0, 1'b0, 1'b0, 1'b0};
            8'h06:   return '{1'b0, 1'b0, 1'b0, 1'b1};
            8'h07:   return '{1'b0, 1'b1, 1'b0, 1'b0};
            8'h08:   return '{1'b0, 1'b1, 1'b1, 1'b0};
            8'h09:   return '{1'b0, 1'b1, 1'b0, 1'b1};
            8'h0a:   return '{1'b0, 1'b1, 1'b1, 1'b1};
            default: return '{1'b1, 1'b0, 1'b0, 1'b0};
        endcase
    endfunction

endpackage

/* File: src/fifo_if.sv */
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 9);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport fill  (output push_valid, output push_data, input push_ready);
    modport store (input push_valid, input push_data, output push_ready,
                   output pop_valid, output pop_data, input pop_ready);
    modport drain (input pop_valid, input pop_data, output pop_ready);
endinterface

/* File: src/packet_fifo.sv */
`timescale 1ns/1ps
module packet_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Both sides
    fifo_if.store    port
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_ptr;
        logic [AW-1:0]               rd_ptr;
        logic [AW:0]                 count;
        logic                        out_valid;
        logic [WIDTH-1:0]            out_data;
    } fifo_state_t;

    fifo_state_t r;
    fifo_state_t n;
    logic        push;
    logic        take;

    // Output word sits in its own register so the drain side sees flops
    always_comb begin
        n = r;
        push = port.push_valid && (r.count != (AW+1)'(DEPTH));
        take = (r.count != '0) && (!r.out_valid || port.pop_ready);
        if (r.out_valid && port.pop_ready) begin
            n.out_valid = 1'b0;
        end
        if (push) begin
            n.mem[r.wr_ptr] = port.push_data;
            n.wr_ptr = (r.wr_ptr == AW'(DEPTH - 1)) ? '0 : r.wr_ptr + 1'b1;
        end
        if (take) begin
            n.out_data  = r.mem[r.rd_ptr];
            n.out_valid = 1'b1;
            n.rd_ptr = (r.rd_ptr == AW'(DEPTH - 1)) ? '0 : r.rd_ptr + 1'b1;
        end
        n.count = r.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, take};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Full stalls the filler; empty is shown by a low pop_valid
    assign port.push_ready = (r.count != (AW+1)'(DEPTH));
    assign port.pop_valid  = r.out_valid;
    assign port.pop_data   = r.out_data;
endmodule

/* File: sim/assembler_sva.sv */
`timescale 1ns/1ps
module assembler_sva
    import assembler_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    // Clock and reset
    input wire logic                          pclk,
    input wire logic                          presetn,
    // Register bus
    input wire logic                          psel,
    input wire logic                          penable,
    input wire logic                          pwrite,
    input wire logic [assembler_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                   pwdata,
    input wire logic [31:0]                   prdata,
    input wire logic                          pready,
    input wire logic                          pslverr,
    // Packet stream and side outputs
    input wire logic [7:0]                    pkt_data,
    input wire logic                          pkt_valid,
    input wire logic                          pkt_last,
    input wire logic                          pkt_ready,
    input wire logic [7:0]                    retx_limit,
    input wire logic                          escape_detected
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Bus phases, used to build the handshake checks
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_done;
        psel && penable && pready;
    endsequence

    ready_after_setup_a: assert property (apb_setup |=> apb_done)
        else $error("ready missing after setup");
    ready_in_access_a: assert property (pready |-> apb_done
        and ($past(psel) && !$past(penable))) else $error("stray ready");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_zero_data_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("error read returned data");
    retx_copy_a: assert property (apb_done ##0 (pwrite && !pslverr
        && paddr == ADDR_RETX) |=> retx_limit == 8'($past(pwdata)))
        else $error("retransmission copy not updated");
    // Stalled radio side must see the byte unchanged
    pkt_hold_a: assert property (pkt_valid && !pkt_ready |=>
        pkt_valid && $stable(pkt_data) && $stable(pkt_last))
        else $error("packet byte changed while stalled");
    esc_pulse_a: assert property (escape_detected |=>
        !escape_detected) else $error("escape flag longer than a pulse");
endmodule

bind serial_packet_assembler assembler_sva #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pkt_data(pkt_data),
    .pkt_valid(pkt_valid), .pkt_last(pkt_last), .pkt_ready(pkt_ready),
    .retx_limit(retx_limit), .escape_detected(escape_detected)
);

/* File: sim/serial_host_model.sv */
`timescale 1ns/1ps
module serial_host_model (
    // Clock and serial line
    input wire logic pclk,
    output logic     rxd
);
    // Line idles high so no false start bit is seen
    initial rxd = 1'b1;

    // One 8N1 character, LSB first; caller matches the device setting
    task automatic send(input int bit_cyc, input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (bit_cyc) @(posedge pclk);
        end
    endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import assembler_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, pkt_data, retx_limit;
    logic [31:0] pwdata, prdata, rd;
    logic        pkt_valid, pkt_last, pkt_ready, serial_rxd, escape_detected;
    logic        er;
    int          bad_count, num_checks, esc_n;

    // Clock and reset
    initial pclk = 1'b0;
    always #10 pclk = ~pclk;

    serial_packet_assembler #(.FIFO_DEPTH(32)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_rxd(serial_rxd),
        .pkt_data(pkt_data), .pkt_valid(pkt_valid), .pkt_last(pkt_last),
        .pkt_ready(pkt_ready), .retx_limit(retx_limit),
        .escape_detected(escape_detected));
    serial_host_model host (.pclk(pclk), .rxd(serial_rxd));

    // Escape pulses counted so a stuck or missing flag shows
    always @(posedge pclk) if (escape_detected === 1'b1) esc_n <= esc_n + 1;

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask

    // Master waits for pready with no assumed latency
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_defaults();
        logic [7:0]  a [8] = '{8'h00, 8'h04, 8'h08, 8'h0c,
                               8'h10, 8'h14, 8'h18, 8'h1c};
        logic [31:0] e [8] = '{32'h0b, 32'h01, 32'h01, 32'h100,
                               32'h05, 32'h0a, 32'h2b, 32'h00};
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, a[i], 32'h0);
            check("default", e[i], rd);
        end
        check("retx port", 32'h05, {24'h0, retx_limit});
    endtask

    task automatic t_regs();
        apb(1'b1, ADDR_RETX, 32'h07);
        apb(1'b0, ADDR_RETX, 32'h0);
        check("retx read", 32'h07, rd);
        check("retx port", 32'h07, {24'h0, retx_limit});
        apb(1'b1, 8'h40, 32'hff);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped err", 32'h1, {31'h0, er});
        check("unmapped data", 32'h0, rd);
        // Mid-run reset must bring the defaults back
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_RETX, 32'h0);
        check("retx after reset", 32'h05, rd);
    endtask

    // Max size of one closes the packet on the first byte
    task automatic t_packet();
        int n;
        n = 0;
        apb(1'b1, ADDR_BIT_RATE, 32'h08);
        apb(1'b1, ADDR_MAX, 32'h01);
        apb(1'b0, ADDR_MIN, 32'h0);
        check("min kept", 32'(DEFAULT_MIN_BYTES), rd);
        host.send(16 * (CLK_HZ / (OVERSAMPLE * RATE_7200)), 8'h2b);
        while (pkt_valid !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        repeat (5) @(posedge pclk);
        check("pkt valid", 32'h1, {31'h0, pkt_valid});
        check("pkt data", 32'h2b, {24'h0, pkt_data});
        check("pkt last", 32'h1, {31'h0, pkt_last});
        pkt_ready <= 1'b1;
        @(posedge pclk);
        pkt_ready <= 1'b0;
        @(negedge pclk);
        check("pkt drained", 32'h0, {31'h0, pkt_valid});
        check("escape pulses", 32'h1, 32'(esc_n));
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("escape status", 32'h8, rd & 32'h0f);
        apb(1'b0, ADDR_FILL, 32'h0);
        check("fill after close", 32'h0, rd);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, pkt_ready} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        esc_n = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_defaults();
        t_regs();
        t_packet();
        final_report();
    end

    // Watchdog sized for one 7200 bps character plus bus traffic
    initial begin
        repeat (90000) @(posedge pclk);
        bad_count++;
        final_report();
    end
endmodule
